// ===== core/eals_pkg.sv
// Constants and types for the effective-address load/store unit
package eals_pkg;
   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int unsigned WORD_W = 16;
   localparam int unsigned ADDR_W = 15;
   localparam int unsigned OFS_W = 9;
   localparam int unsigned LVL_W = 3;

   // ----------------------------------------------------------------
   // Field positions of the first and second instruction words
   // ----------------------------------------------------------------
   localparam int unsigned OPC_MSB = 15;
   localparam int unsigned OPC_LSB = 12;
   localparam int unsigned MODE_MSB = 11;
   localparam int unsigned MODE_LSB = 9;
   localparam int unsigned OFS_MSB = 8;
   localparam int unsigned EXT_TAG_LSB = 8;
   localparam int unsigned EXT_ZERO_BIT = 6;
   localparam int unsigned POST_BIT = 7;
   localparam int unsigned EXT_OP_MSB = 5;
   localparam int unsigned EXT_OP_LSB = 3;
   localparam int unsigned EXT_MODE_MSB = 2;
   localparam int unsigned IND_BIT = 15;
   localparam int unsigned MODE_IND_BIT = 2;

   // ----------------------------------------------------------------
   // Codes
   // ----------------------------------------------------------------
   localparam logic [7:0] EXT_TAG = 8'h0c;
   localparam logic [2:0] MODE_REL = 3'h4;
   localparam logic [2:0] MODE_IDX_X = 3'h5;
   localparam logic [2:0] MODE_IDX_B = 3'h6;
   localparam logic [2:0] MODE_IND = 3'h7;
   localparam logic [2:0] OP_LD_A = 3'h1;
   localparam logic [2:0] OP_LD_B = 3'h2;
   localparam logic [2:0] OP_LD_X = 3'h3;
   localparam logic [2:0] OP_ST_A = 3'h5;
   localparam logic [2:0] OP_ST_B = 3'h6;
   localparam logic [2:0] OP_ST_X = 3'h7;
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_INCR = 3'h4;
   localparam logic [LVL_W-1:0] IND_LIMIT_SHORT = 3'h5;
   localparam logic [LVL_W-1:0] IND_LIMIT_LONG = 3'h4;
   localparam logic [LVL_W-1:0] LEVEL_ONE = 3'h1;
   localparam logic [ADDR_W-1:0] PC_STEP = 15'h0001;
   localparam logic [WORD_W-1:0] REG_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_OPER} eals_state_e;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic [WORD_W-1:0] opnd;
      logic [ADDR_W-1:0] pc;
   } eals_instr_s;
endpackage

// ===== core/eals_addr_add.sv
// Address adder that wraps inside the word address space
`timescale 1ns/1ps
`default_nettype none
module eals_addr_add
   import eals_pkg::*;
(
   input wire logic [ADDR_W-1:0] base_i,
   input wire logic [ADDR_W-1:0] ofs_i,
   output logic [ADDR_W-1:0] sum_o
);
   // Carry out of the top bit is dropped on purpose
   assign sum_o = base_i + ofs_i;
endmodule
`default_nettype wire

// ===== core/eals_core.sv
// Effective-address generation and load/store execution unit
// What this block does
// - Long form, mode 7: operand word with top bit set is a pointer.
// - Low 15 operand bits reach any word; fetched word is address or pointer.
// - Keep fetching while a fetched word is itself indirect.
// - At most five indirect levels for short form, four for long form.
// - Short form mode 5: offset field plus index register.
// - Long form mode 5: index register, pre- or post-indexed.
// - Bit 7 clear: add index first, then walk indirection from the sum.
// - Bit 7 set: walk indirection first, then add the index.
// - Short form mode 6: offset field plus secondary accumulator.
// - Long form mode 6: secondary accumulator, pre- or post-indexed.
// - Short form mode 4: offset field plus program counter, up to 512 ahead.
// - Relative base is the instruction address plus one.
// - Long form mode 4: operand word plus program counter.
// - Next instruction is taken in while the current one executes.
// - Load and store in short, long and immediate forms.
// - Short form offset read per mode field; each operation own opcode.
// - Load writes only the named register with the memory word.
// - Store writes only the effective memory word with the named register.
// - Long form tagged in bits 8-15 with bit 6 clear; operation from bits 3-5.
// - Long loads allow relative, indirect and indexed addressing.
// - Long form mode 7, top bit clear: low 15 bits are the address.
// - Short form mode 7: offset points into the first 512 words.
`timescale 1ns/1ps
`default_nettype none
module eals_core
   import eals_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic INSTR_VALID_I,
   input wire logic [WORD_W-1:0] INSTR_WORD_I,
   input wire logic [WORD_W-1:0] INSTR_OPND_I,
   input wire logic [ADDR_W-1:0] INSTR_PC_I,
   output logic INSTR_READY_O,
   output logic MEM_REQ_O,
   output logic MEM_WE_O,
   output logic [ADDR_W-1:0] MEM_ADDR_O,
   output logic [WORD_W-1:0] MEM_WDATA_O,
   input wire logic MEM_ACK_I,
   input wire logic [WORD_W-1:0] MEM_RDATA_I,
   output logic [WORD_W-1:0] ACC_A_O,
   output logic [WORD_W-1:0] ACC_B_O,
   output logic [WORD_W-1:0] IDX_X_O,
   output logic DONE_O,
   output logic LIMIT_ERR_O,
   output logic UNSUPP_O
);
   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_ext(input logic [WORD_W-1:0] w);
      is_ext = (w[OPC_MSB:EXT_TAG_LSB] == EXT_TAG) && !w[EXT_ZERO_BIT];
   endfunction

   function automatic logic [2:0] op_of(input logic [WORD_W-1:0] w);
      if (is_ext(w)) begin
         op_of = w[EXT_OP_MSB:EXT_OP_LSB];
      end else begin
         op_of = w[OPC_MSB-1:OPC_LSB];
      end
   endfunction

   function automatic logic [2:0] mode_of(input logic [WORD_W-1:0] w);
      if (is_ext(w)) begin
         mode_of = w[EXT_MODE_MSB:0];
      end else begin
         mode_of = w[MODE_MSB:MODE_LSB];
      end
   endfunction

   function automatic logic is_ldst(input logic [WORD_W-1:0] w);
      logic [2:0] op;
      op = op_of(w);
      is_ldst = (is_ext(w) || !w[OPC_MSB]) && (op != OP_NONE) && (op != OP_INCR);
   endfunction

   function automatic logic is_store(input logic [2:0] op);
      is_store = (op == OP_ST_A) || (op == OP_ST_B) || (op == OP_ST_X);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   eals_state_e state_q, state_d;
   eals_instr_s pend_q;
   logic pend_vld_q, pend_vld_d;
   logic ready_q;
   logic take;
   logic [LVL_W-1:0] level_q, level_d, limit_q, limit_d, lvl_nx;
   logic post_q, post_d;
   logic [ADDR_W-1:0] post_base_q, post_base_d;
   logic [2:0] op_q, op_d;
   logic mem_req_q, mem_we_q;
   logic [ADDR_W-1:0] mem_addr_q;
   logic [WORD_W-1:0] mem_wdata_q;
   logic [WORD_W-1:0] acc_a_q, acc_b_q, idx_x_q;
   logic done_q, done_d, lim_err_q, lim_err_d, unsupp_q, unsupp_d;
   logic ld_en;
   logic [WORD_W-1:0] ld_data;
   logic go_oper, go_ptr;
   logic [ADDR_W-1:0] ea_v, ptr_v;
   logic [ADDR_W-1:0] add_base, add_ofs, add_sum, pc_next;
   logic [2:0] mode_w;
   logic ext_w;
   logic [WORD_W-1:0] st_val;

   assign mode_w = mode_of(pend_q.word);
   assign ext_w = is_ext(pend_q.word);

   // ----------------------------------------------------------------
   // Instruction intake
   // ----------------------------------------------------------------
   // One waiting slot lets the next word arrive during execution
   assign pend_vld_d = (INSTR_VALID_I && ready_q) || (pend_vld_q && !take);

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         pend_q <= '0;
         pend_vld_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         if (INSTR_VALID_I && ready_q) begin
            pend_q <= '{word: INSTR_WORD_I, opnd: INSTR_OPND_I, pc: INSTR_PC_I};
         end
         pend_vld_q <= pend_vld_d;
         ready_q <= !pend_vld_d;
      end
   end

   // ----------------------------------------------------------------
   // Address adder
   // ----------------------------------------------------------------
   assign pc_next = pend_q.pc + PC_STEP;

   always_comb begin
      add_base = post_base_q;
      add_ofs = MEM_RDATA_I[ADDR_W-1:0];
      if (state_q == ST_IDLE) begin
         unique case (mode_w)
            MODE_REL: add_base = pc_next;
            MODE_IDX_X: add_base = idx_x_q[ADDR_W-1:0];
            MODE_IDX_B: add_base = acc_b_q[ADDR_W-1:0];
            default: add_base = post_base_q;
         endcase
         if (ext_w) begin
            add_ofs = pend_q.opnd[ADDR_W-1:0];
         end else begin
            add_ofs = ADDR_W'(pend_q.word[OFS_MSB:0]);
         end
      end
   end

   eals_addr_add i_eals_addr_add (
      .base_i(add_base),
      .ofs_i(add_ofs),
      .sum_o(add_sum)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   assign lvl_nx = level_q + LEVEL_ONE;

   always_comb begin
      state_d = state_q;
      level_d = level_q;
      limit_d = limit_q;
      post_d = post_q;
      post_base_d = post_base_q;
      op_d = op_q;
      take = 1'b0;
      ld_en = 1'b0;
      ld_data = MEM_RDATA_I;
      done_d = 1'b0;
      lim_err_d = 1'b0;
      unsupp_d = 1'b0;
      go_oper = 1'b0;
      go_ptr = 1'b0;
      ea_v = add_sum;
      ptr_v = add_sum;
      unique case (state_q)
         ST_IDLE: begin
            if (pend_vld_q) begin
               take = 1'b1;
               op_d = op_of(pend_q.word);
               level_d = '0;
               post_d = 1'b0;
               if (!is_ldst(pend_q.word)) begin
                  unsupp_d = 1'b1;
               end else if (!ext_w) begin
                  limit_d = IND_LIMIT_SHORT;
                  if (!mode_w[MODE_IND_BIT]) begin
                     go_oper = 1'b1;
                     ea_v = ADDR_W'({mode_w[1:0], pend_q.word[OFS_MSB:0]});
                  end else if (mode_w == MODE_IND) begin
                     go_ptr = 1'b1;
                     ptr_v = ADDR_W'(pend_q.word[OFS_MSB:0]);
                  end else begin
                     go_oper = 1'b1;
                  end
               end else begin
                  limit_d = IND_LIMIT_LONG;
                  if (!mode_w[MODE_IND_BIT]) begin
                     // Immediate: operand is the second word itself
                     if (is_store(op_d)) begin
                        go_oper = 1'b1;
                        ea_v = pc_next;
                     end else begin
                        ld_en = 1'b1;
                        ld_data = pend_q.opnd;
                        done_d = 1'b1;
                     end
                  end else if (mode_w == MODE_IND) begin
                     if (pend_q.opnd[IND_BIT]) begin
                        go_ptr = 1'b1;
                        ptr_v = pend_q.opnd[ADDR_W-1:0];
                     end else begin
                        go_oper = 1'b1;
                        ea_v = pend_q.opnd[ADDR_W-1:0];
                     end
                  end else if (pend_q.word[POST_BIT]) begin
                     post_base_d = add_base;
                     if (pend_q.opnd[IND_BIT]) begin
                        post_d = 1'b1;
                        go_ptr = 1'b1;
                        ptr_v = pend_q.opnd[ADDR_W-1:0];
                     end else begin
                        go_oper = 1'b1;
                     end
                  end else begin
                     if (pend_q.opnd[IND_BIT]) begin
                        go_ptr = 1'b1;
                     end else begin
                        go_oper = 1'b1;
                     end
                  end
               end
            end
         end
         ST_PTR: begin
            if (MEM_ACK_I) begin
               level_d = lvl_nx;
               if (MEM_RDATA_I[IND_BIT]) begin
                  // Chain too deep: abandon the instruction, nothing is written
                  if (lvl_nx >= limit_q) begin
                     lim_err_d = 1'b1;
                     state_d = ST_IDLE;
                  end else begin
                     go_ptr = 1'b1;
                     ptr_v = MEM_RDATA_I[ADDR_W-1:0];
                  end
               end else begin
                  go_oper = 1'b1;
                  ea_v = post_q ? add_sum : MEM_RDATA_I[ADDR_W-1:0];
               end
            end
         end
         ST_OPER: begin
            if (MEM_ACK_I) begin
               ld_en = !is_store(op_q);
               done_d = 1'b1;
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      if (go_ptr) begin
         state_d = ST_PTR;
      end
      if (go_oper) begin
         state_d = ST_OPER;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_q <= ST_IDLE;
         level_q <= '0;
         limit_q <= '0;
         post_q <= 1'b0;
         post_base_q <= '0;
         op_q <= OP_NONE;
         done_q <= 1'b0;
         lim_err_q <= 1'b0;
         unsupp_q <= 1'b0;
      end else begin
         state_q <= state_d;
         level_q <= level_d;
         limit_q <= limit_d;
         post_q <= post_d;
         post_base_q <= post_base_d;
         op_q <= op_d;
         done_q <= done_d;
         lim_err_q <= lim_err_d;
         unsupp_q <= unsupp_d;
      end
   end

   // ----------------------------------------------------------------
   // Memory port and register file
   // ----------------------------------------------------------------
   assign st_val = (op_d == OP_ST_A) ? acc_a_q : (op_d == OP_ST_B) ? acc_b_q : idx_x_q;
   // Request, address and data stay frozen until the ack edge
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         mem_req_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_addr_q <= '0;
         mem_wdata_q <= '0;
      end else if (go_ptr || go_oper) begin
         mem_req_q <= 1'b1;
         mem_we_q <= go_oper && is_store(op_d);
         mem_addr_q <= go_ptr ? ptr_v : ea_v;
         mem_wdata_q <= st_val;
      end else if (MEM_ACK_I) begin
         mem_req_q <= 1'b0;
      end
   end
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         acc_a_q <= REG_RESET;
         acc_b_q <= REG_RESET;
         idx_x_q <= REG_RESET;
      end else if (ld_en) begin
         unique case (op_d)
            OP_LD_A: acc_a_q <= ld_data;
            OP_LD_B: acc_b_q <= ld_data;
            OP_LD_X: idx_x_q <= ld_data;
            default: ;
         endcase
      end
   end
   assign INSTR_READY_O = ready_q;
   assign MEM_REQ_O = mem_req_q;
   assign MEM_WE_O = mem_we_q;
   assign MEM_ADDR_O = mem_addr_q;
   assign MEM_WDATA_O = mem_wdata_q;
   assign ACC_A_O = acc_a_q;
   assign ACC_B_O = acc_b_q;
   assign IDX_X_O = idx_x_q;
   assign DONE_O = done_q;
   assign LIMIT_ERR_O = lim_err_q;
   assign UNSUPP_O = unsupp_q;

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   chk_req_hold: assert property (
      mem_req_q && !MEM_ACK_I |=> $stable({mem_req_q, mem_we_q, mem_addr_q}))
      else $error("Memory request dropped or moved before ack");
   chk_idle_quiet: assert property (state_q == ST_IDLE |-> !mem_req_q)
      else $error("Memory request while idle");
   chk_level_cap: assert property (level_q <= limit_q)
      else $error("Indirect level beyond limit");
   chk_err_no_req: assert property (lim_err_q |-> !mem_req_q)
      else $error("Memory request after chain abandoned");
   chk_ptr_read: assert property (state_q == ST_PTR && mem_req_q |-> !mem_we_q)
      else $error("Pointer fetch issued as a write");
   chk_regs_hold: assert property (!ld_en |=> $stable({acc_a_q, acc_b_q, idx_x_q}))
      else $error("Register changed without a load");
   cov_chain_step: cover property (state_q == ST_PTR && MEM_ACK_I && MEM_RDATA_I[IND_BIT]);
   cov_limit_hit: cover property (lim_err_q);
   cov_post_done: cover property (done_q && post_q);
endmodule
`default_nettype wire

// ===== tb/eals_mem_model.sv
// Word memory that answers the unit's requests after a settable delay
`timescale 1ns/1ps
`default_nettype none
module eals_mem_model
   import eals_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] delay_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [WORD_W-1:0] wdata_i,
   output logic ack_o,
   output logic [WORD_W-1:0] rdata_o
);
   logic [WORD_W-1:0] mem [0:32767];
   logic [3:0] wait_q;
   // Read bus flips when idle, so a stale word never passes for data
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         wait_q <= 4'h0;
         rdata_o <= 16'h5a5a;
      end else if (req_i && !ack_o && wait_q >= delay_i) begin
         ack_o <= 1'b1;
         wait_q <= 4'h0;
         if (we_i) begin
            mem[addr_i] <= wdata_i;
            rdata_o <= ~rdata_o;
         end else begin
            rdata_o <= mem[addr_i];
         end
      end else begin
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
         wait_q <= req_i ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb_eals_core.sv
// Self-checking bench for the effective-address load/store unit
`timescale 1ns/1ps
`default_nettype none
module tb_eals_core;
   import eals_pkg::*;
   logic clk, rst_n, valid, req, we, ack, ready, done, lerr, unsupp;
   logic [WORD_W-1:0] word, opnd, wdata, rdata, acc_a, acc_b, idx_x, ea, eb, ex;
   logic [ADDR_W-1:0] pc, addr;
   logic [3:0] dly;
   logic seen_err, seen_unsupp;
   int errors = 0;
   int n_compared = 0;

   eals_core i_eals_core (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .INSTR_VALID_I(valid),
      .INSTR_WORD_I(word), .INSTR_OPND_I(opnd), .INSTR_PC_I(pc), .INSTR_READY_O(ready),
      .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata),
      .MEM_ACK_I(ack), .MEM_RDATA_I(rdata), .ACC_A_O(acc_a), .ACC_B_O(acc_b),
      .IDX_X_O(idx_x), .DONE_O(done), .LIMIT_ERR_O(lerr), .UNSUPP_O(unsupp));
   eals_mem_model i_eals_mem_model (.clk_i(clk), .rst_n_i(rst_n), .delay_i(dly),
      .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic regs();
      chk("acc_a", acc_a, ea);
      chk("acc_b", acc_b, eb);
      chk("idx_x", idx_x, ex);
   endtask
   function automatic logic [15:0] sw(input logic [2:0] op, input logic [2:0] m,
                                      input logic [8:0] o);
      return {1'b0, op, m, o};
   endfunction
   function automatic logic [15:0] lw(input logic [2:0] op, input logic [2:0] m, input logic p);
      return {EXT_TAG, p, 1'b0, op, m};
   endfunction
   task automatic pm(input logic [14:0] a, input logic [15:0] v);
      i_eals_mem_model.mem[a] = v;
   endtask
   // Request held until the edge that samples ready, then wait for completion
   task automatic issue(input logic [15:0] w, input logic [15:0] o, input logic [14:0] p);
      int n;
      @(posedge clk);
      valid <= 1'b1;
      word <= w;
      opnd <= o;
      pc <= p;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ready !== 1'b1 && n < 300);
      valid <= 1'b0;
      seen_err = 1'b0;
      seen_unsupp = 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (lerr === 1'b1) seen_err = 1'b1;
         if (unsupp === 1'b1) seen_unsupp = 1'b1;
      end while (done !== 1'b1 && lerr !== 1'b1 && unsupp !== 1'b1 && n < 300);
      if (n >= 300) chk("completion", 16'h0, 16'h1);
      repeat (2) @(posedge clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_rel();
      pm(15'h0300, 16'h1234);
      issue(sw(OP_LD_A, MODE_REL, 9'h1ff), 16'h0, 15'h0100);
      ea = 16'h1234;
      regs();
   endtask
   task automatic t_imm_direct();
      issue(lw(OP_LD_X, 3'h0, 1'b0), 16'h0010, 15'h0);
      ex = 16'h0010;
      regs();
      pm(15'h0400, 16'hbeef);
      issue(lw(OP_LD_B, MODE_IND, 1'b0), 16'h0400, 15'h0);
      eb = 16'hbeef;
      regs();
   endtask
   task automatic t_stores();
      pm(15'h0014, 16'h0);
      pm(15'h0016, 16'h0);
      issue(sw(OP_ST_A, MODE_IDX_X, 9'h005), 16'h0, 15'h0);
      chk("mem 0015", i_eals_mem_model.mem[15'h0015], 16'h1234);
      chk("mem 0014", i_eals_mem_model.mem[15'h0014], 16'h0);
      chk("mem 0016", i_eals_mem_model.mem[15'h0016], 16'h0);
      regs();
      issue(sw(OP_ST_X, MODE_IDX_B, 9'h1f0), 16'h0, 15'h0);
      chk("mem 40df", i_eals_mem_model.mem[15'h40df], 16'h0010);
   endtask
   task automatic t_index();
      // Pre-index: add first, then follow the pointer
      pm(15'h3fef, 16'h0500);
      pm(15'h0500, 16'h5555);
      issue(lw(OP_LD_A, MODE_IDX_B, 1'b0), 16'h8100, 15'h0);
      ea = 16'h5555;
      regs();
      // Post-index: follow the pointer, then add
      pm(15'h0200, 16'h0600);
      pm(15'h0610, 16'h6666);
      issue(lw(OP_LD_A, MODE_IDX_X, 1'b1), 16'h8200, 15'h0);
      ea = 16'h6666;
      regs();
   endtask
   task automatic t_wrap();
      issue(lw(OP_ST_B, MODE_REL, 1'b0), 16'h0020, 15'h7ff0);
      chk("mem 0011", i_eals_mem_model.mem[15'h0011], 16'hbeef);
   endtask
   task automatic t_chains();
      dly = 4'h5;
      pm(15'h0010, 16'h8020);
      pm(15'h0020, 16'h0700);
      pm(15'h0700, 16'h4321);
      issue(sw(OP_LD_B, MODE_IND, 9'h010), 16'h0, 15'h0);
      eb = 16'h4321;
      regs();
      pm(15'h0030, 16'h0710);
      pm(15'h0710, 16'h7777);
      issue(lw(OP_LD_X, MODE_IND, 1'b0), 16'h8030, 15'h0);
      ex = 16'h7777;
      regs();
      dly = 4'h0;
   endtask
   task automatic t_limit();
      pm(15'h0040, 16'h8040);
      issue(sw(OP_LD_A, MODE_IND, 9'h040), 16'h0, 15'h0);
      chk("short limit", {15'h0, seen_err}, 16'h1);
      issue(lw(OP_LD_B, MODE_IND, 1'b0), 16'h8040, 15'h0);
      chk("long limit", {15'h0, seen_err}, 16'h1);
      regs();
      // Deepest chains that are still legal must finish
      pm(15'h0050, 16'h8051);
      pm(15'h0051, 16'h8052);
      pm(15'h0052, 16'h8053);
      pm(15'h0053, 16'h8054);
      pm(15'h0054, 16'h0060);
      pm(15'h0060, 16'h0abc);
      issue(sw(OP_LD_A, MODE_IND, 9'h050), 16'h0, 15'h0);
      chk("short depth", {15'h0, seen_err}, 16'h0);
      issue(lw(OP_LD_B, MODE_IND, 1'b0), 16'h8051, 15'h0);
      chk("long depth", {15'h0, seen_err}, 16'h0);
      ea = 16'h0abc;
      eb = 16'h0abc;
      regs();
   endtask
   task automatic t_unsupp();
      issue(sw(OP_NONE, 3'h0, 9'h000), 16'h0, 15'h0);
      chk("unsupported", {15'h0, seen_unsupp}, 16'h1);
      regs();
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      errors++;
      print_verdict();
   end
   initial begin
      rst_n = 1'b0;
      valid = 1'b0;
      word = 16'h0;
      opnd = 16'h0;
      pc = 15'h0;
      dly = 4'h1;
      ea = REG_RESET;
      eb = REG_RESET;
      ex = REG_RESET;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      regs();
      t_rel();
      t_imm_direct();
      t_stores();
      t_index();
      t_wrap();
      t_chains();
      t_limit();
      t_unsupp();
      print_verdict();
   end
endmodule
`default_nettype wire
